// ===== hdl/alarm_pkg.sv
// alarm_pkg: constants, types and helpers shared by the alarm monitor
// assumes one 100 MHz clock domain and a 16-bit register port
//
// What this block does
// RULE_01: two alarm channels, each with its own source, threshold, count, filter and mode.
// RULE_02: alarm 2 source in control bits 15:12, codes 0 off to 8 rotation.
// RULE_03: alarm 1 source in control bits 11:8, same source codes.
// RULE_04: control bits 6 and 5 turn on rate-of-change for alarm 2 and 1.
// RULE_05: rate mode averages consecutive sample differences over count, then compares.
// RULE_06: sample count is 8 bits, resets to one; zero and one both mean one.
// RULE_07: threshold bit 15 picks greater-than (1) or less-than (0).
// RULE_08: threshold bits 13:0 hold magnitude in source format; bit 14 unused.
// RULE_09: control bits 4 and 3 pick filtered or raw data for alarm 2 and 1.
// RULE_10: incline and angle sources always use filtered data.
// RULE_11: control bit 2 enables the alarm indicator on an auxiliary pin.
// RULE_12: control bit 1 sets indicator polarity, 1 active high.
// RULE_13: control bit 0 picks the pin, 1 second, 0 first.
// RULE_14: status bits 9 and 8 report alarm 2 and alarm 1 active.
// RULE_15: status bits 5, 3, 2 flag self-test, serial and flash errors.
// RULE_16: status bit 1 set when supply reads above 3.625 V.
// RULE_17: status bit 0 set when supply reads below 2.975 V.
// RULE_18: every status flag clears on each status register read.
// RULE_19: a flag whose condition persists sets again on the next sample cycle.
// RULE_20: host reads status to clear flash failure before flash access again.
// RULE_21: enabled indicator shows alarm level on its pin, overriding general I/O.
// RULE_22: alarms evaluate once per new sample; a disabled source never alarms.

package alarm_pkg;

   // ---------------------------------------------------------------
   // register addresses on the register port
   // ---------------------------------------------------------------
   localparam logic [2:0]  ADDR_THR1    = 3'h0;
   localparam logic [2:0]  ADDR_THR2    = 3'h1;
   localparam logic [2:0]  ADDR_CNT1    = 3'h2;
   localparam logic [2:0]  ADDR_CNT2    = 3'h3;
   localparam logic [2:0]  ADDR_CTRL    = 3'h4;
   localparam logic [2:0]  ADDR_FLAGS   = 3'h5;

   // ---------------------------------------------------------------
   // field positions, masks and reset values
   // ---------------------------------------------------------------
   localparam int          CTRL_SRC1_LSB = 8;
   localparam int          CTRL_SRC2_LSB = 12;
   localparam int          CTRL_ROC1     = 5;
   localparam int          CTRL_ROC2     = 6;
   localparam int          CTRL_FILT1    = 3;
   localparam int          CTRL_FILT2    = 4;
   localparam int          CTRL_IND_EN   = 2;
   localparam int          CTRL_IND_POL  = 1;
   localparam int          CTRL_IND_SEL  = 0;
   localparam int          THR_POL       = 15;
   localparam int          MAG_W         = 14;
   localparam int          CNT_W         = 8;
   localparam logic [15:0] CTRL_WMASK    = 16'hFF7F;
   localparam logic [15:0] THR_WMASK     = 16'hBFFF;
   localparam logic [15:0] CNT_WMASK     = 16'h00FF;
   localparam logic [15:0] CTRL_RST      = 16'h0000;
   localparam logic [15:0] THR_RST       = 16'h0000;
   localparam logic [15:0] CNT_RST       = 16'h0001;
   localparam logic [15:0] FLAGS_RST     = 16'h0000;
   localparam int          FLG_SUP_LO    = 0;
   localparam int          FLG_SUP_HI    = 1;
   localparam int          FLG_FLASH     = 2;
   localparam int          FLG_COMM      = 3;
   localparam int          FLG_SELFTEST  = 5;
   localparam int          FLG_ALM1      = 8;

   // ---------------------------------------------------------------
   // sources and supply limits
   // ---------------------------------------------------------------
   localparam int          NUM_SRC     = 8;
   localparam logic [3:0]  SRC_OFF     = 4'h0;
   localparam logic [3:0]  SRC_SUPPLY  = 4'h1;
   localparam logic [3:0]  SRC_XINC    = 4'h6;
   localparam logic [3:0]  SRC_YINC    = 4'h7;
   localparam logic [3:0]  SRC_ROT     = 4'h8;
   localparam int          SUPPLY_HI_MV      = 3625;
   localparam int          SUPPLY_LO_MV      = 2975;
   localparam int          SUPPLY_UV_PER_LSB = 1000;
   localparam logic [13:0] SUPPLY_HI_CODE =
      14'(SUPPLY_HI_MV * 1000 / SUPPLY_UV_PER_LSB);
   localparam logic [13:0] SUPPLY_LO_CODE =
      14'(SUPPLY_LO_MV * 1000 / SUPPLY_UV_PER_LSB);

   typedef logic [MAG_W-1:0] sample_t;

   typedef struct packed {
      sample_t [NUM_SRC-1:0] raw;
      sample_t [NUM_SRC-1:0] filt;
   } sample_bus_t;

   typedef struct packed {
      logic [3:0]       src;
      logic             roc;
      logic [CNT_W-1:0] count;
      logic [15:0]      thr;
   } chan_cfg_t;

   function automatic logic src_valid(input logic [3:0] src);
      src_valid = (src != SRC_OFF) && (src <= SRC_ROT);
   endfunction

   // angle sources ignore the filter bit
   function automatic sample_t pick_sample(input logic [3:0]  src,
                                           input logic        filt,
                                           input sample_bus_t bus);
      logic [2:0] idx;
      logic       use_filt;
      idx      = 3'(src - 4'h1);
      use_filt = filt || (src == SRC_XINC) || (src == SRC_YINC)
                 || (src == SRC_ROT);                          // [RULE_10]
      if (!src_valid(src)) begin
         pick_sample = '0;
      end else if (use_filt) begin
         pick_sample = bus.filt[idx];                          // [RULE_09]
      end else begin
         pick_sample = bus.raw[idx];
      end
   endfunction

endpackage

// ===== hdl/alarm_channel.sv
// alarm_channel: one threshold comparator, static or rate-of-change
// assumes sample_stb is a one-cycle pulse on ref_clk per new sample
`timescale 1ns/10ps
`default_nettype none

module alarm_channel (
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   input  wire logic                 sample_stb,
   input  wire logic                 restart,
   input  wire alarm_pkg::chan_cfg_t cfg,
   input  wire alarm_pkg::sample_t   sample,
   output logic                      alarm
);
   import alarm_pkg::*;

   // ---------------------------------------------------------------
   // arithmetic
   // ---------------------------------------------------------------
   logic signed [22:0]     acc_q;
   logic [CNT_W-1:0]       cnt_q;
   logic signed [13:0]     prev_q;
   logic                   prev_ok_q;

   wire                    active  = src_valid(cfg.src);       // [RULE_22]
   wire [CNT_W-1:0]        n_eff   = (cfg.count < 8'h02) ? 8'h01 : cfg.count; // [RULE_06]
   wire signed [13:0]      cur     = $signed(sample);
   wire signed [22:0]      diff    = 23'(cur) - 23'(prev_q);
   wire signed [22:0]      sum     = acc_q + diff;
   wire signed [22:0]      n_ext   = $signed({15'h0000, n_eff});
   wire signed [22:0]      avg     = sum / n_ext;              // [RULE_05]
   wire                    last    = (cnt_q + 8'h01) == n_eff;
   wire                    rate_ev = cfg.roc && prev_ok_q && last;
   wire                    eval    = sample_stb && active && (!cfg.roc || rate_ev); // [RULE_04]
   wire signed [22:0]      value   = cfg.roc ? avg : 23'(cur);
   wire signed [22:0]      thr_ext = 23'($signed(cfg.thr[MAG_W-1:0])); // [RULE_08]
   wire                    trip    = cfg.thr[THR_POL] ? (value > thr_ext)
                                                      : (value < thr_ext); // [RULE_07]

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst || !active || restart) begin
         acc_q     <= '0;
         cnt_q     <= '0;
         prev_ok_q <= 1'b0;
      end else if (sample_stb) begin
         prev_ok_q <= 1'b1;
         if (cfg.roc && prev_ok_q) begin
            acc_q <= last ? '0 : sum;
            cnt_q <= last ? '0 : cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         prev_q <= '0;
      end else if (sample_stb) begin
         prev_q <= cur;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst || !active) begin
         alarm <= 1'b0;                                        // [RULE_22]
      end else if (eval) begin
         alarm <= trip;
      end
   end

endmodule

`default_nettype wire

// ===== hdl/alarm_monitor.sv
// alarm_monitor: two alarm channels, error flag register and indicator pins
// assumes sample_stb, error inputs and register strobes come from ref_clk logic
`timescale 1ns/10ps
`default_nettype none

module alarm_monitor (
   input  wire logic                   ref_clk,
   input  wire logic                   nrst,

   // sample stream
   input  wire logic                   sample_stb,
   input  wire alarm_pkg::sample_bus_t sensor,

   // error events from the rest of the device
   input  wire logic                   selftest_err,
   input  wire logic                   comm_err,
   input  wire logic                   flash_err,

   // register port
   input  wire logic [2:0]             reg_addr,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [15:0]            reg_wdata,
   output logic [15:0]                 reg_rdata,

   // general-purpose use of the auxiliary pins
   input  wire logic [1:0]             gpio_out,
   input  wire logic [1:0]             gpio_oe,

   // auxiliary pins
   output logic                        aux_pin_one,
   output logic                        aux_pin_one_oe,
   output logic                        aux_pin_two,
   output logic                        aux_pin_two_oe,

   // state for the rest of the device
   output logic [1:0]                  alarm_status,
   output logic                        flash_access_ok
);
   import alarm_pkg::*;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [2:0] addr,
                                input logic [2:0] want);
      hit = (addr == want);
   endfunction

   wire wr_thr1  = reg_wr && hit(reg_addr, ADDR_THR1);
   wire wr_thr2  = reg_wr && hit(reg_addr, ADDR_THR2);
   wire wr_cnt1  = reg_wr && hit(reg_addr, ADDR_CNT1);
   wire wr_cnt2  = reg_wr && hit(reg_addr, ADDR_CNT2);
   wire wr_ctrl  = reg_wr && hit(reg_addr, ADDR_CTRL);

   // a read of status is the only read with a side effect
   wire rd_flags = reg_rd && hit(reg_addr, ADDR_FLAGS);

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   logic [15:0] thr1_q;
   logic [15:0] thr2_q;
   logic [15:0] cnt1_q;
   logic [15:0] cnt2_q;
   logic [15:0] ctrl_q;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         thr1_q <= THR_RST;
      end else if (wr_thr1) begin
         thr1_q <= reg_wdata & THR_WMASK;                      // [RULE_08]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         thr2_q <= THR_RST;
      end else if (wr_thr2) begin
         thr2_q <= reg_wdata & THR_WMASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cnt1_q <= CNT_RST;                                    // [RULE_06]
      end else if (wr_cnt1) begin
         cnt1_q <= reg_wdata & CNT_WMASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cnt2_q <= CNT_RST;
      end else if (wr_cnt2) begin
         cnt2_q <= reg_wdata & CNT_WMASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         ctrl_q <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= reg_wdata & CTRL_WMASK;
      end
   end

   // ---------------------------------------------------------------
   // channel configuration
   // ---------------------------------------------------------------
   chan_cfg_t   cfg [2];
   sample_t     chan_sample [2];
   logic [1:0]  restart;
   logic [1:0]  alarm;

   // a new count or mode would mix old and new differences,
   // so any write that reshapes a channel restarts its average
   assign restart[0] = wr_ctrl || wr_cnt1;
   assign restart[1] = wr_ctrl || wr_cnt2;

   assign cfg[0] = '{src:   ctrl_q[CTRL_SRC1_LSB +: 4],   // [RULE_03]
                     roc:   ctrl_q[CTRL_ROC1],            // [RULE_04]
                     count: cnt1_q[CNT_W-1:0],
                     thr:   thr1_q};

   assign cfg[1] = '{src:   ctrl_q[CTRL_SRC2_LSB +: 4],   // [RULE_02]
                     roc:   ctrl_q[CTRL_ROC2],
                     count: cnt2_q[CNT_W-1:0],
                     thr:   thr2_q};

   assign chan_sample[0] = pick_sample(cfg[0].src,
                                       ctrl_q[CTRL_FILT1],
                                       sensor);        // [RULE_09]
   assign chan_sample[1] = pick_sample(cfg[1].src,
                                       ctrl_q[CTRL_FILT2],
                                       sensor);

   // ---------------------------------------------------------------
   // alarm channels
   // ---------------------------------------------------------------
   // each channel keeps its own averaging state
   genvar k;
   generate
      for (k = 0; k < 2; k++) begin : g_chan
         alarm_channel u_chan (
            .ref_clk    (ref_clk),
            .nrst       (nrst),
            .sample_stb (sample_stb),
            .restart    (restart[k]),
            .cfg        (cfg[k]),
            .sample     (chan_sample[k]),
            .alarm      (alarm[k])
         );                                                    // [RULE_01]
      end
   endgenerate

   assign alarm_status = alarm;

   // ---------------------------------------------------------------
   // sample cycle timing
   // ---------------------------------------------------------------
   // channels update their alarm on the strobe edge, so the
   // flags look at the alarm level one cycle later
   logic stb_q;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         stb_q <= 1'b0;
      end else begin
         stb_q <= sample_stb;
      end
   end

   // ---------------------------------------------------------------
   // supply monitor
   // ---------------------------------------------------------------
   wire sample_t supply   = sensor.raw[0];
   wire          sup_hi   = supply > SUPPLY_HI_CODE;           // [RULE_16]
   wire          sup_lo   = supply < SUPPLY_LO_CODE;           // [RULE_17]

   // ---------------------------------------------------------------
   // error flag register
   // ---------------------------------------------------------------
   logic [15:0] flags_q;
   logic [15:0] flag_set;
   logic [15:0] flags_d;

   // level conditions re-arm only on a sample cycle; error
   // events are caught in whatever cycle they arrive
   always_comb begin
      flag_set                 = '0;
      flag_set[FLG_ALM1]       = stb_q && alarm[0];            // [RULE_14]
      flag_set[FLG_ALM1 + 1]   = stb_q && alarm[1];
      flag_set[FLG_SELFTEST]   = selftest_err;                 // [RULE_15]
      flag_set[FLG_COMM]       = comm_err;
      flag_set[FLG_FLASH]      = flash_err;
      flag_set[FLG_SUP_HI]     = sample_stb && sup_hi;         // [RULE_19]
      flag_set[FLG_SUP_LO]     = sample_stb && sup_lo;
   end

   // a set in the cycle of the clearing read survives it
   assign flags_d = (rd_flags ? FLAGS_RST : flags_q) | flag_set; // [RULE_18]

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         flags_q <= FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   // flash stays locked until the failure flag has been read away
   assign flash_access_ok = !flags_q[FLG_FLASH];               // [RULE_20]

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   wire [15:0] rd_mux =
      hit(reg_addr, ADDR_THR1)  ? thr1_q  :
      hit(reg_addr, ADDR_THR2)  ? thr2_q  :
      hit(reg_addr, ADDR_CNT1)  ? cnt1_q  :
      hit(reg_addr, ADDR_CNT2)  ? cnt2_q  :
      hit(reg_addr, ADDR_CTRL)  ? ctrl_q  :
      hit(reg_addr, ADDR_FLAGS) ? flags_q :
      16'h0000;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end

   // ---------------------------------------------------------------
   // indicator pins
   // ---------------------------------------------------------------
   wire       ind_en   = ctrl_q[CTRL_IND_EN];                  // [RULE_11]
   wire       ind_pol  = ctrl_q[CTRL_IND_POL];
   wire       ind_sel  = ctrl_q[CTRL_IND_SEL];
   wire       any_alm  = |alarm;
   wire       ind_lvl  = ind_pol ? any_alm : !any_alm;         // [RULE_12]

   logic [1:0] pin_o_q;
   logic [1:0] pin_oe_q;
   logic [1:0] pin_own;

   // the pin that carries the indicator drops its general use
   assign pin_own[0] = ind_en && !ind_sel;                     // [RULE_13]
   assign pin_own[1] = ind_en && ind_sel;

   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_pin
         always_ff @(posedge ref_clk) begin
            if (!nrst) begin
               pin_o_q[p]  <= 1'b0;
               pin_oe_q[p] <= 1'b0;
            end else if (pin_own[p]) begin
               pin_o_q[p]  <= ind_lvl;                         // [RULE_21]
               pin_oe_q[p] <= 1'b1;
            end else begin
               pin_o_q[p]  <= gpio_out[p];
               pin_oe_q[p] <= gpio_oe[p];
            end
         end
      end
   endgenerate

   assign aux_pin_one    = pin_o_q[0];
   assign aux_pin_one_oe = pin_oe_q[0];
   assign aux_pin_two    = pin_o_q[1];
   assign aux_pin_two_oe = pin_oe_q[1];

endmodule

`default_nettype wire

// ===== test/alarm_chk.sv
// alarm_chk: port-level assertions for the alarm monitor
// assumes one ref_clk domain with synchronous active-low nrst
`timescale 1ns/10ps
`default_nettype none

module alarm_chk
   import alarm_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic        sample_stb,
   input wire logic        selftest_err,
   input wire logic        comm_err,
   input wire logic        flash_err,
   input wire logic [2:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic [1:0]  gpio_out,
   input wire logic [1:0]  gpio_oe,
   input wire logic        aux_pin_one,
   input wire logic        aux_pin_one_oe,
   input wire logic [1:0]  alarm_status,
   input wire logic        flash_access_ok
);
   logic [15:0] ctl_q;
   logic        wr_ctl;
   logic        rd_flg;
   logic        quiet;
   logic        lvl;
   assign wr_ctl = reg_wr && (reg_addr == ADDR_CTRL);
   assign rd_flg = reg_rd && (reg_addr == ADDR_FLAGS);
   assign quiet  = !(selftest_err || comm_err || flash_err || sample_stb);
   assign lvl    = ctl_q[CTRL_IND_POL] ? (|alarm_status) : !(|alarm_status);
   // shadow of the control register; the pin checks need the mode
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         ctl_q <= CTRL_RST;
      end else if (wr_ctl) begin
         ctl_q <= reg_wdata & CTRL_WMASK;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // --
   // assertions
   // --
   a_read_clears: assert property (
      quiet ##1 (rd_flg && quiet) ##1 quiet ##1 (rd_flg && quiet) |=> reg_rdata[5:0] == 6'h00)
      else $error("flags survived a status read");
   a_flag_layout: assert property (rd_flg |=>
      reg_rdata[15:10] == 6'h00 && reg_rdata[7:6] == 2'h0 && !reg_rdata[4])
      else $error("unused status bits read nonzero");
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_pin_alarm: assert property (
      ctl_q[CTRL_IND_EN] && !ctl_q[CTRL_IND_SEL] && !$past(wr_ctl) && $stable(alarm_status)
      |-> aux_pin_one_oe && aux_pin_one == lvl)
      else $error("pin one does not show the alarm level");
   a_pin_gpio: assert property (
      (!ctl_q[CTRL_IND_EN] || ctl_q[CTRL_IND_SEL]) && $past(nrst) && !$past(wr_ctl)
      |-> aux_pin_one == $past(gpio_out[0]) && aux_pin_one_oe == $past(gpio_oe[0]))
      else $error("pin one does not follow general use");
   a_flash_gate: assert property (flash_err |-> ##[1:2] !flash_access_ok)
      else $error("flash access still allowed after failure");
   a_alarm_on_stb: assert property ($changed(alarm_status) |->
      $past(sample_stb) || $past(sample_stb, 2) || $past(reg_wr) || $past(reg_wr, 2))
      else $error("alarm moved without a sample");
   a_self_sticky: assert property (
      selftest_err ##1 (!reg_rd) [*2] ##1 rd_flg |=> reg_rdata[FLG_SELFTEST])
      else $error("self-test flag lost before read");
   c_alarm: cover property ($rose(alarm_status[0]));
   c_pin: cover property (aux_pin_one_oe && ctl_q[CTRL_IND_EN]);
   c_flash: cover property (!flash_access_ok);
endmodule

bind alarm_monitor alarm_chk alarm_chk_i (.ref_clk, .nrst, .sample_stb, .selftest_err,
   .comm_err, .flash_err, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .gpio_out,
   .gpio_oe, .aux_pin_one, .aux_pin_one_oe, .alarm_status, .flash_access_ok);
`default_nettype wire

// ===== test/alarm_host.sv
// alarm_host: register-port master standing in for the host processor
// assumes calls start at a falling edge of ref_clk
`timescale 1ns/10ps
`default_nettype none

module alarm_host (
   input  wire logic        ref_clk,
   input  wire logic [15:0] reg_rdata,
   output logic [2:0]       reg_addr,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic [15:0]      reg_wdata
);
   initial begin
      reg_addr  = 3'h7;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 16'h0000;
   end
   // idle address and data are inverted so stale values never look valid;
   // the idle cycle keeps a strobe from being dropped and raised at once
   task automatic wr(input logic [2:0] a, input logic [15:0] v);
      reg_addr  = a;
      reg_wdata = v;
      reg_wr    = 1'b1;
      @(negedge ref_clk);
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~v;
      @(negedge ref_clk);
   endtask
   task automatic rd(input logic [2:0] a, output logic [15:0] v);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge ref_clk);
      reg_rd   = 1'b0;
      reg_addr = ~a;
      v        = reg_rdata;
      @(negedge ref_clk);
   endtask
endmodule
`default_nettype wire

// ===== test/dual_alarm_monitor_status_tb.sv
// dual_alarm_monitor_status_tb: self-checking bench for alarm_monitor
// assumes alarm_pkg, the design, alarm_host and alarm_chk compile first
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD %s exp %h got %h", n, e, g); end end

module dual_alarm_monitor_status_tb;
   import alarm_pkg::*;
   typedef struct {
      logic [3:0] src; logic filt; logic [15:0] thr; sample_t raw, flt; logic hit;
   } row_t;
   logic        ref_clk, nrst, sample_stb, selftest_err, comm_err, flash_err;
   logic        reg_wr, reg_rd, aux_pin_one, aux_pin_one_oe, aux_pin_two, aux_pin_two_oe;
   logic        flash_access_ok;
   logic [2:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic [1:0]  gpio_out, gpio_oe, alarm_status;
   sample_bus_t sensor;
   int          bad_count, compares;
   row_t        rows [9] = '{'{4'h1, 1'b0, 16'h8100, 14'h0200, 14'h0000, 1'b1},
      '{4'h2, 1'b1, 16'h8100, 14'h0200, 14'h0000, 1'b0},
      '{4'h3, 1'b0, 16'h0100, 14'h3FFF, 14'h0200, 1'b1},
      '{4'h4, 1'b0, 16'h0100, 14'h0100, 14'h0000, 1'b0},
      '{4'h5, 1'b0, 16'hBF00, 14'h0000, 14'h3FFF, 1'b1},
      '{4'h6, 1'b0, 16'h8100, 14'h0200, 14'h0000, 1'b0},
      '{4'h7, 1'b0, 16'h8100, 14'h0000, 14'h0200, 1'b1},
      '{4'h8, 1'b0, 16'h8100, 14'h0000, 14'h0200, 1'b1},
      '{4'h0, 1'b0, 16'hBF00, 14'h0000, 14'h0000, 1'b0}};
   logic [2:0]  wa [4] = '{ADDR_THR1, ADDR_CNT2, ADDR_CTRL, 3'h6};
   logic [15:0] wm [4] = '{16'hBFFF, 16'h00FF, 16'hFF7F, 16'h0000};
   sample_t     sv [7] = '{14'h0E2A, 14'h0E29, 14'h0B9E, 14'h0B9F, 14'h0E2A, 14'h0E2A, 14'h0E2A};
   logic [1:0]  se [7] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h2};
   logic [15:0] ic [5] = '{16'h0107, 16'h0105, 16'h0106, 16'h0106, 16'h0102};
   sample_t     iv [5] = '{14'h0064, 14'h0064, 14'h0064, 14'h3F00, 14'h0064};
   logic [3:0]  ie [5] = '{4'hF, 4'hD, 4'hD, 4'h5, 4'hD};

   alarm_monitor alarm_monitor_i (.ref_clk, .nrst, .sample_stb, .sensor, .selftest_err,
      .comm_err, .flash_err, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .gpio_out,
      .gpio_oe, .aux_pin_one, .aux_pin_one_oe, .aux_pin_two, .aux_pin_two_oe,
      .alarm_status, .flash_access_ok);
   alarm_host alarm_host_i (.ref_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);

   task automatic samp(input sample_t r, input sample_t f);
      for (int i = 0; i < NUM_SRC; i++) begin
         sensor.raw[i]  = r;
         sensor.filt[i] = f;
      end
      sample_stb = 1'b1;
      @(negedge ref_clk);
      sample_stb = 1'b0;
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic tally_and_finish();
      if (bad_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      nrst = 1'b0;
      sample_stb = 1'b0;
      sensor = '0;
      {selftest_err, comm_err, flash_err} = 3'b000;
      gpio_out = 2'b01;
      gpio_oe = 2'b11;
      bad_count = 0;
      compares = 0;
      repeat (6) @(negedge ref_clk);
      nrst = 1'b1;
      for (int a = 0; a < 8; a++) begin
         alarm_host_i.rd(3'(a), d);
         `CHK("reset", (a == 2 || a == 3) ? 16'h0001 : 16'h0000, d)
      end
      for (int k = 0; k < 4; k++) begin
         alarm_host_i.wr(wa[k], 16'hFFFF);
         alarm_host_i.rd(wa[k], d);
         `CHK("mask", wm[k], d)
      end
      for (int c = 0; c < 2; c++) begin
         for (int k = 0; k < 9; k++) begin
            alarm_host_i.wr(c ? ADDR_THR2 : ADDR_THR1, rows[k].thr);
            alarm_host_i.wr(ADDR_CTRL, (16'(rows[k].src) << (CTRL_SRC1_LSB + 4 * c))
                                       | (16'(rows[k].filt) << (CTRL_FILT1 + c)));
            samp(rows[k].raw, rows[k].flt);
            `CHK("alarm", rows[k].hit, alarm_status[c])
         end
      end
      // rate of change over two differences, then a count of zero acting as one
      alarm_host_i.wr(ADDR_CNT1, 16'h0002);
      alarm_host_i.wr(ADDR_THR1, 16'h002D);
      alarm_host_i.wr(ADDR_CNT2, 16'h0002);
      alarm_host_i.wr(ADDR_THR2, 16'h002D);
      alarm_host_i.wr(ADDR_CTRL, 16'h2260);
      samp(14'h0000, '0);
      samp(14'h001E, '0);
      `CHK("rate_early", 2'b00, alarm_status)
      samp(14'h003C, '0);
      `CHK("rate", 2'b11, alarm_status)
      alarm_host_i.wr(ADDR_CNT1, 16'h0000);
      samp(14'h0000, '0);
      samp(14'h0032, '0);
      `CHK("rate_one", 1'b0, alarm_status[0])
      alarm_host_i.rd(ADDR_FLAGS, d);
      for (int k = 0; k < 7; k++) begin
         if (k != 5) samp(sv[k], '0);
         alarm_host_i.rd(ADDR_FLAGS, d);
         `CHK("supply", se[k], d[1:0])
      end
      {selftest_err, comm_err, flash_err} = 3'b111;
      @(negedge ref_clk);
      {selftest_err, comm_err, flash_err} = 3'b000;
      repeat (2) @(negedge ref_clk);
      `CHK("flash_ok", 1'b0, flash_access_ok)
      alarm_host_i.rd(ADDR_FLAGS, d);
      `CHK("errors", 6'h2C, d[5:0])
      `CHK("flash_ok", 1'b1, flash_access_ok)
      alarm_host_i.rd(ADDR_FLAGS, d);
      `CHK("cleared", 6'h00, d[5:0])
      alarm_host_i.wr(ADDR_THR1, 16'h8000);
      for (int k = 0; k < 5; k++) begin
         alarm_host_i.wr(ADDR_CTRL, ic[k]);
         samp(iv[k], '0);
         `CHK("pins", ie[k], {aux_pin_one, aux_pin_one_oe, aux_pin_two, aux_pin_two_oe})
      end
      alarm_host_i.rd(ADDR_FLAGS, d);
      `CHK("alarm_flag", 2'b01, d[9:8])
      tally_and_finish();
   end
endmodule
`default_nettype wire
